// ---- verilog/hbf_map.vh ----
`ifndef HBF_MAP_VH
`define HBF_MAP_VH

// ****************************************
// Register offsets
// ****************************************
`define HBF_REG_DATA       3'h0
`define HBF_REG_BUFFER_CONTROL_WORD    3'h1
`define HBF_REG_HCTRL      3'h2
`define HBF_REG_HSTAT      3'h3
`define HBF_REG_FSTAT      3'h4

// ****************************************
// Field positions
// ****************************************
`define HBF_BUF_FRAME_EN   7
`define HBF_HC_PAR_SEL     4
`define HBF_HC_RX_IE       6
`define HBF_HC_TX_IE       7
`define HBF_HS_RX_RDY      6
`define HBF_HS_TX_RDY      7
`define HBF_FS_RX_ERR      0
`define HBF_FS_RX_EOF      1
`define HBF_FS_TX_END      2

// ****************************************
// Reset values
// ****************************************
`define HBF_BUFFER_CONTROL_WORD_RST    16'h0000
`define HBF_HCTRL_RST      16'h0000

// ****************************************
// Framing symbols and checksum
// ****************************************
`define HBF_FLAG           8'h7E
`define HBF_ABORT_CODE     8'hFF
`define HBF_BADCRC_CODE    8'h7E
`define HBF_GOOD_CODE      8'h00
`define HBF_CRC_PRESET     16'hFFFF
`define HBF_CRC_POLY_REV   16'h8408
`define HBF_CRC_RESIDUE    16'hF0B8

// ****************************************
// Bit counts
// ****************************************
`define HBF_STUFF_RUN      3'd5
`define HBF_FLAG_RUN       3'd6
`define HBF_ABORT_RUN      3'd7
`define HBF_LAST_BIT       3'd7

`endif

// ---- verilog/hbf_crc16.v ----
`timescale 1ns/1ps
`include "hbf_map.vh"

module hbf_crc16 (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        ce,
  input  wire        clr,
  input  wire        en,
  input  wire        din,
  output reg  [15:0] crc_q,
  output wire [15:0] crc_nx
);

  // ****************************************
  // Serial checksum, low order bit first
  // ****************************************
  wire fb;

  assign fb     = crc_q[0] ^ din;
  assign crc_nx = {1'b0, crc_q[15:1]} ^ (fb ? `HBF_CRC_POLY_REV : 16'h0000);

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      crc_q <= `HBF_CRC_PRESET;
    end else if (ce) begin
      if (clr) begin
        crc_q <= `HBF_CRC_PRESET;
      end else if (en) begin
        crc_q <= crc_nx;
      end
    end
  end

endmodule // hbf_crc16

// ---- verilog/hbf_byte_framer.v ----
// The address map and strobed register access were left to the implementer.
`timescale 1ns/1ps
`include "hbf_map.vh"


module hbf_byte_framer #(
  parameter DW = 16
) (
  input  wire          clk,
  input  wire          sys_rst,
  input  wire          ce,
  input  wire          bit_tick,
  input  wire [2:0]    reg_addr,
  input  wire [DW-1:0] reg_wdata,
  input  wire          reg_wr,
  input  wire          reg_rd,
  output reg  [DW-1:0] reg_rdata,
  output wire          host_irq,
  input  wire          rx_line,
  output reg           tx_line
);

  localparam TX_FLAG = 4'b0001;
  localparam TX_DATA = 4'b0010;
  localparam TX_CRC1 = 4'b0100;
  localparam TX_CRC2 = 4'b1000;

  // ****************************************
  // Host registers
  // ****************************************
  reg  [DW-1:0] buffer_control_word_q;
  reg  [DW-1:0] host_control_register_q;
  reg  [7:0]    host_data_register_q;
  reg           rx_ready_flag_q;
  reg           rx_frame_error_flag_q;
  reg           rx_eof_flag_q;
  reg           tx_frame_end_flag_q;
  reg           tx_hold_v_q;
  reg  [7:0]    tx_hold_q;

  wire parallel_transfer_select = host_control_register_q[`HBF_HC_PAR_SEL];
  wire tx_irq_enable            = host_control_register_q[`HBF_HC_TX_IE];
  wire rx_irq_enable            = host_control_register_q[`HBF_HC_RX_IE];
  wire frame_en = buffer_control_word_q[`HBF_BUF_FRAME_EN] & parallel_transfer_select;
  wire tx_ready_flag            = frame_en & ~tx_hold_v_q;

  wire wr_data  = reg_wr & (reg_addr == `HBF_REG_DATA);
  wire rd_data  = reg_rd & (reg_addr == `HBF_REG_DATA);
  wire tick     = frame_en & bit_tick;

  assign host_irq = (tx_irq_enable & tx_ready_flag) | (rx_irq_enable & rx_ready_flag_q);

  wire [DW-1:0] host_status_register;
  wire [DW-1:0] frame_status_register;

  assign host_status_register  = {{(DW-8){1'b0}}, tx_ready_flag, rx_ready_flag_q, 6'b00_0000};
  assign frame_status_register = {{(DW-3){1'b0}}, tx_frame_end_flag_q, rx_eof_flag_q,
                                  rx_frame_error_flag_q};

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      buffer_control_word_q   <= `HBF_BUFFER_CONTROL_WORD_RST;
      host_control_register_q <= `HBF_HCTRL_RST;
    end else if (ce) begin
      if (reg_wr && reg_addr == `HBF_REG_HCTRL) begin
        host_control_register_q <= reg_wdata;
      end
      if (reg_wr && reg_addr == `HBF_REG_BUFFER_CONTROL_WORD) begin
        buffer_control_word_q <= reg_wdata;
        // Enable only takes while parallel transfer is selected
        buffer_control_word_q[`HBF_BUF_FRAME_EN] <= reg_wdata[`HBF_BUF_FRAME_EN] &
                                                    parallel_transfer_select;
      end
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= {DW{1'b0}};
    end else if (ce) begin
      if (reg_rd) begin
        case (reg_addr)
          `HBF_REG_DATA:    reg_rdata <= {{(DW-8){1'b0}}, host_data_register_q};
          `HBF_REG_BUFFER_CONTROL_WORD: reg_rdata <= buffer_control_word_q;
          `HBF_REG_HCTRL:   reg_rdata <= host_control_register_q;
          `HBF_REG_HSTAT:   reg_rdata <= host_status_register;
          `HBF_REG_FSTAT:   reg_rdata <= frame_status_register;
          default:          reg_rdata <= {DW{1'b0}};
        endcase
      end else begin
        reg_rdata <= {DW{1'b0}};
      end
    end
  end

  // ****************************************
  // Transmitter
  // ****************************************
  reg  [3:0]  tx_st_q;
  reg  [7:0]  tx_sh_q;
  reg  [2:0]  tx_cnt_q;
  reg  [2:0]  tx_ones_q;
  reg  [7:0]  tx_crc_hi_q;
  wire [15:0] tx_crc;
  wire [15:0] tx_crc_nx;

  wire tx_stuff_slot = (tx_ones_q == `HBF_STUFF_RUN);
  wire tx_content    = (tx_st_q != TX_FLAG);
  wire tx_crc_en     = tick & ~tx_stuff_slot & (tx_st_q == TX_DATA);
  wire tx_load       = wr_data & tx_ready_flag;
  wire tx_take       = tick & ~tx_stuff_slot & (tx_cnt_q == `HBF_LAST_BIT) & tx_hold_v_q &
                       ((tx_st_q == TX_FLAG) | (tx_st_q == TX_DATA));

  hbf_crc16 u_tx_crc (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .clr     (tx_st_q == TX_FLAG),
    .en      (tx_crc_en),
    .din     (tx_sh_q[0]),
    .crc_q   (tx_crc),
    .crc_nx  (tx_crc_nx)
  );

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_hold_v_q <= 1'b0;
      tx_hold_q   <= 8'h00;
    end else if (ce) begin
      if (!frame_en) begin
        tx_hold_v_q <= 1'b0;
      end else if (tx_load) begin
        tx_hold_v_q <= 1'b1;
        tx_hold_q   <= reg_wdata[7:0];
      end else if (tx_take) begin
        tx_hold_v_q <= 1'b0;
      end
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_st_q             <= TX_FLAG;
      tx_sh_q             <= `HBF_FLAG;
      tx_cnt_q            <= 3'd0;
      tx_ones_q           <= 3'd0;
      tx_crc_hi_q         <= 8'h00;
      tx_frame_end_flag_q <= 1'b0;
      tx_line             <= 1'b1;
    end else if (ce) begin
      if (!frame_en) begin
        tx_st_q             <= TX_FLAG;
        tx_sh_q             <= `HBF_FLAG;
        tx_cnt_q            <= 3'd0;
        tx_ones_q           <= 3'd0;
        tx_frame_end_flag_q <= 1'b0;
        tx_line             <= 1'b1;
      end else if (bit_tick) begin
        if (tx_stuff_slot) begin
          tx_line   <= 1'b0;
          tx_ones_q <= 3'd0;
        end else begin
          tx_line   <= tx_sh_q[0];
          tx_ones_q <= (tx_content && tx_sh_q[0]) ? tx_ones_q + 3'd1 : 3'd0;
          if (tx_cnt_q != `HBF_LAST_BIT) begin
            tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
            tx_cnt_q <= tx_cnt_q + 3'd1;
          end else begin
            tx_cnt_q <= 3'd0;
            case (tx_st_q)
              TX_FLAG: begin
                // Shared flag: a closing flag opens the next frame
                if (tx_hold_v_q) begin
                  tx_sh_q <= tx_hold_q;
                  tx_st_q <= TX_DATA;
                end else begin
                  tx_sh_q <= `HBF_FLAG;
                end
              end
              TX_DATA: begin
                if (tx_hold_v_q) begin
                  tx_sh_q <= tx_hold_q;
                end else begin
                  tx_sh_q             <= ~tx_crc_nx[7:0];
                  tx_crc_hi_q         <= ~tx_crc_nx[15:8];
                  tx_frame_end_flag_q <= 1'b1;
                  tx_st_q             <= TX_CRC1;
                end
              end
              TX_CRC1: begin
                tx_sh_q <= tx_crc_hi_q;
                tx_st_q <= TX_CRC2;
              end
              TX_CRC2: begin
                tx_sh_q             <= `HBF_FLAG;
                tx_frame_end_flag_q <= 1'b0;
                tx_st_q             <= TX_FLAG;
              end
              default: begin
                tx_sh_q <= `HBF_FLAG;
                tx_st_q <= TX_FLAG;
              end
            endcase
          end
        end
      end
    end
  end

  // ****************************************
  // Receiver
  // ****************************************
  reg        rx_s1_q;
  reg        rx_s2_q;
  reg  [2:0] rx_ones_q;
  reg  [6:0] rx_dly_q;
  reg  [2:0] rx_dcnt_q;
  reg  [7:0] rx_byte_q;
  reg  [2:0] rx_bcnt_q;
  reg        rx_have_q;
  reg        rx_sync_q;
  wire [15:0] rx_crc;
  wire [15:0] rx_crc_nx;

  wire rx_bit    = rx_s2_q;
  wire rx_abort  = tick & rx_bit & (rx_ones_q == `HBF_FLAG_RUN);
  wire rx_flag   = tick & ~rx_bit & (rx_ones_q == `HBF_FLAG_RUN);
  wire rx_stuff  = tick & ~rx_bit & (rx_ones_q == `HBF_STUFF_RUN);
  wire rx_push   = tick & ~rx_stuff & ~rx_flag & (rx_ones_q < `HBF_FLAG_RUN);
  wire rx_emit   = rx_push & rx_sync_q & (rx_dcnt_q == `HBF_ABORT_RUN);
  wire rx_inside = rx_sync_q & (rx_have_q | (rx_bcnt_q != 3'd0));
  wire rx_byte_done = rx_emit & (rx_bcnt_q == `HBF_LAST_BIT);
  wire [7:0] rx_byte_nx = {rx_dly_q[0], rx_byte_q[7:1]};

  hbf_crc16 u_rx_crc (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .clr     (~rx_sync_q | rx_flag | rx_abort),
    .en      (rx_emit),
    .din     (rx_dly_q[0]),
    .crc_q   (rx_crc),
    .crc_nx  (rx_crc_nx)
  );

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
    end else if (ce) begin
      rx_s1_q <= rx_line;
      rx_s2_q <= rx_s1_q;
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_ones_q <= 3'd0;
      rx_dly_q  <= 7'h00;
      rx_dcnt_q <= 3'd0;
      rx_byte_q <= 8'h00;
      rx_bcnt_q <= 3'd0;
      rx_have_q <= 1'b0;
      rx_sync_q <= 1'b0;
    end else if (ce) begin
      if (!frame_en) begin
        rx_ones_q <= 3'd0;
        rx_dcnt_q <= 3'd0;
        rx_bcnt_q <= 3'd0;
        rx_have_q <= 1'b0;
        rx_sync_q <= 1'b0;
      end else if (tick) begin
        if (rx_bit) begin
          rx_ones_q <= (rx_ones_q == `HBF_ABORT_RUN) ? rx_ones_q : rx_ones_q + 3'd1;
        end else begin
          rx_ones_q <= 3'd0;
        end
        if (rx_flag || rx_abort) begin
          // Bits held back in the delay belong to the flag itself
          rx_dcnt_q <= 3'd0;
          rx_bcnt_q <= 3'd0;
          rx_have_q <= 1'b0;
          rx_sync_q <= rx_flag;
        end else if (rx_push) begin
          rx_dly_q <= {rx_bit, rx_dly_q[6:1]};
          if (rx_dcnt_q != `HBF_ABORT_RUN) begin
            rx_dcnt_q <= rx_dcnt_q + 3'd1;
          end
          if (rx_emit) begin
            rx_byte_q <= rx_byte_nx;
            rx_bcnt_q <= rx_bcnt_q + 3'd1;
            if (rx_byte_done) begin
              rx_have_q <= 1'b1;
            end
          end
        end
      end
    end
  end

  // ****************************************
  // Received byte delivery
  // ****************************************
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      host_data_register_q  <= 8'h00;
      rx_ready_flag_q       <= 1'b0;
      rx_eof_flag_q         <= 1'b0;
      rx_frame_error_flag_q <= 1'b0;
    end else if (ce) begin
      if (rx_byte_done) begin
        host_data_register_q  <= rx_byte_nx;
        rx_eof_flag_q         <= 1'b0;
        rx_frame_error_flag_q <= 1'b0;
        rx_ready_flag_q       <= 1'b1;
      end else if (rx_flag && rx_inside) begin
        rx_eof_flag_q   <= 1'b1;
        rx_ready_flag_q <= 1'b1;
        if (rx_bcnt_q == 3'd0 && rx_crc == `HBF_CRC_RESIDUE) begin
          host_data_register_q  <= `HBF_GOOD_CODE;
          rx_frame_error_flag_q <= 1'b0;
        end else begin
          host_data_register_q  <= `HBF_BADCRC_CODE;
          rx_frame_error_flag_q <= 1'b1;
        end
      end else if (rx_abort && rx_inside) begin
        host_data_register_q  <= `HBF_ABORT_CODE;
        rx_eof_flag_q         <= 1'b1;
        rx_frame_error_flag_q <= 1'b1;
        rx_ready_flag_q       <= 1'b1;
      end else if (rd_data || !frame_en) begin
        rx_ready_flag_q <= 1'b0;
      end
    end
  end

endmodule // hbf_byte_framer

// ---- test/hbf_byte_framer_props.sv ----
`timescale 1ns/1ps
`include "hbf_map.vh"
module hbf_byte_framer_props #(
  parameter DW = 16
) (
  input wire          clk,
  input wire          sys_rst,
  input wire          ce,
  input wire          bit_tick,
  input wire [2:0]    reg_addr,
  input wire [DW-1:0] reg_wdata,
  input wire          reg_wr,
  input wire          reg_rd,
  input wire [DW-1:0] reg_rdata,
  input wire          host_irq,
  input wire          tx_line
);
  // ********
  // Shadow of control words, run of ones on the line
  // ********
  reg  [DW-1:0] hc_q;
  reg  [DW-1:0] bc_q;
  reg  [2:0]    ones_q;
  reg           zero_q;
  wire          wr_ok = reg_wr & ce;
  wire          tk    = bit_tick & ce;
  wire          fr_en = hc_q[`HBF_HC_PAR_SEL] & bc_q[`HBF_BUF_FRAME_EN];
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hc_q <= {DW{1'b0}};
      bc_q <= {DW{1'b0}};
      ones_q <= 3'd0;
      zero_q <= 1'b0;
    end else begin
      if (wr_ok && reg_addr == `HBF_REG_HCTRL)
        hc_q <= reg_wdata;
      if (wr_ok && reg_addr == `HBF_REG_BUFFER_CONTROL_WORD)
        bc_q <= reg_wdata & ~({{(DW-1){1'b0}}, !hc_q[`HBF_HC_PAR_SEL]} << `HBF_BUF_FRAME_EN);
      if (!fr_en) begin
        ones_q <= 3'd0;
        zero_q <= 1'b0;
      end else if (tk) begin
        // Idle ones before the first flag are not counted
        zero_q <= zero_q | !tx_line;
        ones_q <= (!tx_line || !zero_q) ? 3'd0 : (ones_q == 3'd7) ? 3'd7 : ones_q + 3'd1;
      end
    end
  end
  // ********
  // Properties
  // ********
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  property p_rd_quiet;
    $past(ce) && !$past(reg_rd) |-> reg_rdata == {DW{1'b0}};
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside slot");
  property p_hc_rd;
    $past(reg_rd && ce && reg_addr == `HBF_REG_HCTRL) |-> reg_rdata == $past(hc_q);
  endproperty
  a_hc_rd: assert property (p_hc_rd) else $error("control readback");
  property p_bc_rd;
    $past(reg_rd && ce && reg_addr == `HBF_REG_BUFFER_CONTROL_WORD) |-> reg_rdata == $past(bc_q);
  endproperty
  a_bc_rd: assert property (p_bc_rd) else $error("buffer word readback");
  property p_unmapped;
    $past(reg_rd && ce && reg_addr > `HBF_REG_FSTAT) |-> reg_rdata == {DW{1'b0}};
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_data_hi;
    $past(reg_rd && ce && reg_addr == `HBF_REG_DATA) |-> reg_rdata[DW-1:8] == 8'h00;
  endproperty
  a_data_hi: assert property (p_data_hi) else $error("data upper bits");
  property p_tx_hold;
    !$past(tk) |-> $stable(tx_line);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("line moved off tick");
  property p_idle_mark;
    $past(tk && !fr_en) |-> tx_line;
  endproperty
  a_idle_mark: assert property (p_idle_mark) else $error("line not mark");
  property p_stuff;
    ones_q <= 3'd6;
  endproperty
  a_stuff: assert property (p_stuff) else $error("too many ones");
  property p_irq_off;
    hc_q[7:6] == 2'b00 |-> !host_irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq while masked");
  c_irq: cover property (host_irq);
  c_flag_run: cover property (ones_q == 3'd6);
  c_fstat_rd: cover property (reg_rd && reg_addr == `HBF_REG_FSTAT);
endmodule // hbf_byte_framer_props

bind hbf_byte_framer hbf_byte_framer_props #(.DW(DW)) u_hbf_byte_framer_props (
  .clk(clk), .sys_rst(sys_rst), .ce(ce), .bit_tick(bit_tick), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .host_irq(host_irq), .tx_line(tx_line));

// ---- test/hbf_line_peer.sv ----
`timescale 1ns/1ps
// ********
// Far end of the line: loopback with faults
// ********
module hbf_line_peer (
  input  wire       clk,
  input  wire       bit_tick,
  input  wire       tx_line,
  input  wire [1:0] hit,
  output wire       rx_line
);
  reg [3:0] left_q = 4'h0;
  reg       flip_q = 1'b0;
  always @(posedge clk) begin
    if (hit != 2'b00) begin
      left_q <= (hit == 2'b01) ? 4'h3 : 4'hE;
      flip_q <= (hit == 2'b01);
    end else if (bit_tick && left_q != 4'h0) begin
      left_q <= left_q - 4'h1;
    end
  end
  // One bit inverted, or twelve ones forced
  assign rx_line = (flip_q && left_q == 4'h1) ? ~tx_line :
                   (!flip_q && left_q != 4'h0 && left_q < 4'hD) ? 1'b1 : tx_line;
endmodule // hbf_line_peer

// ---- test/hbf_byte_framer_bench.sv ----
`timescale 1ns/1ps
`include "hbf_map.vh"
module hbf_byte_framer_bench;
  reg         clk = 1'b0;
  reg         sys_rst = 1'b1;
  reg         ce = 1'b1;
  reg         bit_tick = 1'b0;
  reg  [2:0]  reg_addr = 3'h0;
  reg  [15:0] reg_wdata = 16'h0000;
  reg         reg_wr = 1'b0;
  reg         reg_rd = 1'b0;
  reg  [1:0]  hit = 2'b00;
  reg         rd_d = 1'b0;
  wire [15:0] reg_rdata;
  wire        host_irq;
  wire        rx_line;
  wire        tx_line;
  reg  [31:0] expq[$];
  reg  [9:0]  fb[$];
  reg  [31:0] me;
  reg  [15:0] v;
  integer     miscompares = 0;
  integer     n_tests = 0;
  integer     seed = 23996;
  integer     tdiv = 8;
  integer     tcnt = 0;
  integer     cyc = 0;

  hbf_byte_framer u_hbf_byte_framer (.clk(clk), .sys_rst(sys_rst), .ce(ce),
    .bit_tick(bit_tick), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .host_irq(host_irq), .rx_line(rx_line),
    .tx_line(tx_line));
  hbf_line_peer u_hbf_line_peer (.clk(clk), .bit_tick(bit_tick), .tx_line(tx_line),
    .hit(hit), .rx_line(rx_line));

  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    tcnt <= (tcnt >= tdiv - 1) ? 0 : tcnt + 1;
    bit_tick <= (tcnt == 0);
    rd_d <= reg_rd;
    if (cyc == 30000) begin
      miscompares = miscompares + 1;
      report_and_stop;
    end
  end
  always @(negedge clk) begin
    if (rd_d) begin
      me = expq.pop_front();
      if (me[31:16] != 16'h0000)
        check("rdata", reg_rdata & me[31:16], me[15:0]);
    end
  end
  // ********
  // Bus tasks and checking
  // ********
  task check(input string nm, input [15:0] seen, input [15:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("[ERR] %s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task wr(input [2:0] a, input [15:0] d);
    begin
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [2:0] a, input [15:0] m, input [15:0] x);
    begin
      expq.push_back({m, x & m});
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      v = reg_rdata;
    end
  endtask
  function [15:0] crc_upd(input [15:0] c, input [7:0] b);
    integer k;
    begin
      crc_upd = c;
      for (k = 0; k < 8; k = k + 1)
        crc_upd = (crc_upd[0] ^ b[k]) ? (crc_upd >> 1) ^ 16'h8408 : crc_upd >> 1;
    end
  endfunction
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  // ********
  // One frame through the loopback; md 0 good, 1 bit error, 2 abort
  // ********
  task frame(input integer n, input [1:0] md);
    reg [7:0]  tb[$];
    reg [31:0] rnd;
    reg [31:0] e;
    reg [15:0] c;
    reg [15:0] f;
    reg [15:0] m;
    integer    i;
    integer    done;
    reg        te;
    begin
      tb.delete();
      fb.delete();
      c = 16'hFFFF;
      for (i = 0; i < n; i = i + 1) begin
        rnd = $random(seed);
        tb.push_back(md == 2'b00 ? rnd[7:0] : 8'h00);
        c = crc_upd(c, tb[i]);
        fb.push_back({2'b00, tb[i]});
      end
      c = ~c;
      fb.push_back({2'b00, c[7:0]});
      fb.push_back({2'b00, c[15:8]});
      fb.push_back({2'b10, 8'h00});
      i = 0;
      done = 0;
      te = 1'b0;
      while (done == 0) begin
        rd(`HBF_REG_HSTAT, 16'h0000, 16'h0000);
        f = v;
        if (f[7] && i < n) begin
          if (i == 2 && md != 2'b00) begin
            hit <= md;
            @(posedge clk);
            hit <= 2'b00;
          end
          wr(`HBF_REG_DATA, {8'h00, tb[i]});
          i = i + 1;
        end
        if (f[6]) begin
          e = (md == 2'b00 && fb.size() > 0) ? {22'h0, fb.pop_front()} : 32'h0;
          m = (md == 2'b00) ? 16'hFFFF : 16'h0000;
          rd(`HBF_REG_FSTAT, m & 16'h0003, {14'h0, e[9:8]});
          f = v;
          te = te | f[2];
          rd(`HBF_REG_DATA, m, {8'h00, e[7:0]});
          if (f[1]) begin
            done = 1;
            // Earlier bytes of a failed frame are read but not checked
            if (md != 2'b00) begin
              check("last", v, md == 2'b01 ? 16'h007E : 16'h00FF);
              check("ferr", f & 16'h0003, 16'h0003);
            end
          end
        end
      end
      // Cut frame still runs on the line; let it close first
      if (md == 2'b10)
        repeat (48) @(posedge clk iff bit_tick);
      rd(`HBF_REG_FSTAT, 16'h0004, 16'h0000);
      if (md == 2'b00) begin
        check("count", {15'h0, fb.size() != 0}, 16'h0000);
        check("txend", {15'h0, te}, 16'h0001);
      end
    end
  endtask
  // ********
  // Main sequence
  // ********
  initial begin : main
    integer   k;
    integer   found;
    reg [7:0] sh;
    reg       held;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rd(`HBF_REG_BUFFER_CONTROL_WORD, 16'hFFFF, 16'h0000);
    rd(`HBF_REG_HCTRL, 16'hFFFF, 16'h0000);
    rd(3'h7, 16'hFFFF, 16'h0000);
    wr(`HBF_REG_BUFFER_CONTROL_WORD, 16'h0080);
    rd(`HBF_REG_BUFFER_CONTROL_WORD, 16'hFFFF, 16'h0000);
    check("idle", {15'h0, tx_line}, 16'h0001);
    $display("end reset");
    wr(`HBF_REG_HCTRL, 16'h0010);
    wr(`HBF_REG_BUFFER_CONTROL_WORD, 16'h0080);
    rd(`HBF_REG_BUFFER_CONTROL_WORD, 16'hFFFF, 16'h0080);
    rd(`HBF_REG_DATA, 16'h0000, 16'h0000);
    wr(`HBF_REG_HCTRL, 16'h0090);
    repeat (20) @(posedge clk);
    @(negedge clk);
    check("irq", {15'h0, host_irq}, 16'h0001);
    wr(`HBF_REG_HCTRL, 16'h0010);
    @(negedge clk);
    check("irqoff", {15'h0, host_irq}, 16'h0000);
    sh = 8'h00;
    found = 0;
    for (k = 0; k < 40; k = k + 1) begin
      @(posedge clk iff bit_tick);
      @(negedge clk);
      sh = {tx_line, sh[7:1]};
      if (sh == 8'h7E)
        found = found + 1;
    end
    check("flags", (found >= 4) ? 16'h0001 : 16'h0000, 16'h0001);
    // Clock enable low: the line must hold its bit
    @(posedge clk);
    ce <= 1'b0;
    @(negedge clk);
    held = tx_line;
    repeat (30) @(negedge clk);
    check("freeze", {15'h0, tx_line}, {15'h0, held});
    @(posedge clk);
    ce <= 1'b1;
    $display("end enable");
    frame(5, 2'b00);
    frame(4, 2'b01);
    frame(4, 2'b10);
    tdiv <= 13;
    frame(3, 2'b00);
    $display("end frames");
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rd(`HBF_REG_BUFFER_CONTROL_WORD, 16'hFFFF, 16'h0000);
    check("idle2", {15'h0, tx_line}, 16'h0001);
    $display("end second reset");
    report_and_stop;
  end
endmodule // hbf_byte_framer_bench
